// ---- rlp_pkg.sv ----
// Package for the reset and low-power controller: timing counts,
// memory map bounds, power states and grouped signals.
// Assumes a single bus clock domain; nothing here holds logic.
package rlp_pkg;

   // Oscillator stabilisation counts in bus clock cycles
   localparam int unsigned STAB_CERAMIC_CYC = 128;
   localparam int unsigned STAB_CRYSTAL_CYC = 4064;
   localparam int unsigned STAB_W           = 12;

   // Opcode fetch address map
   localparam int unsigned ADDR_W = 13;
   localparam logic [12:0] RAM_LO = 13'h0080;
   localparam logic [12:0] RAM_HI = 13'h00ff;
   localparam logic [12:0] ROM_LO = 13'h1600;
   localparam logic [12:0] ROM_HI = 13'h1fff;

   // Single-ended zero length that marks a bus reset, in bit times
   localparam logic [2:0] USB_SE0_MIN_BITS = 3'h4;

   // Length of the illegal-fetch reset pulse in cycles
   localparam logic [3:0] ILL_HOLD_CYC = 4'h4;

   // Synchroniser reset values: pin idles high, others low
   localparam logic [4:0] SYNC_RST_VAL = 5'h01;

   // Reset value of the own-drive history that masks the reset pin echo
   localparam logic [2:0] DRIVE_MASK_RST = 3'h0;

   typedef enum logic [1:0] {
      rlp_st_run  = 2'b00,
      rlp_st_wait = 2'b01,
      rlp_st_stop = 2'b10,
      rlp_st_stab = 2'b11
   } rlp_pwr_state_t;

   typedef struct packed {
      logic        valid;
      logic [12:0] addr;
   } rlp_fetch_t;

   typedef struct packed {
      logic irq;
      logic usb;
      logic timer1;
      logic multi_function_timer;
   } rlp_int_t;

   typedef struct packed {
      logic clr_int_mask;
      logic set_ext_int_enable;
   } rlp_lp_side_t;

endpackage : rlp_pkg

// ---- rlp_stab_timer.sv ----
// Oscillator stabilisation down-counter.
// Assumes start and count_en come from logic on clk_sys.
`timescale 1ns/10ps
module rlp_stab_timer #(
   parameter int unsigned LEN_CYC = rlp_pkg::STAB_CRYSTAL_CYC,
   parameter int unsigned W       = rlp_pkg::STAB_W
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic clk_en,
   input  wire logic start,
   input  wire logic count_en,
   output logic      busy,
   output logic      done
);

   localparam logic [W-1:0] LEN = W'(LEN_CYC);
   localparam logic [W-1:0] ONE = W'(1);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // Reload on start; otherwise count only while the oscillator runs
   assign cnt_next = start ? LEN :
                     (count_en && cnt_reg != '0) ? cnt_reg - ONE : cnt_reg;
   assign busy     = (cnt_reg != '0);
   assign done     = !start && count_en && (cnt_reg == ONE);

   // Power-up starts with a full count pending
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= LEN;
      end else if (clk_en) begin
         cnt_reg <= cnt_next;
      end
   end

endmodule : rlp_stab_timer

// ---- rlp_ctrl.sv ----
// Reset combiner and STOP/WAIT power-state controller.
// Assumes CPU-side strobes and interrupts are on clk_sys; reset pin,
// supply monitor, oscillator ready and USB line levels are asynchronous.
`timescale 1ns/10ps

// Functional notes
// RULE1: Low reset pin asserts system reset
// RULE2: Low-voltage reset drives reset pin low
// RULE3: Only four source endings update operating mode
// RULE4: Power-up holds reset 128 or 4064 cycles
// RULE5: Reset stays while other sources remain
// RULE6: SE0 four bit times sets flag, resets
// RULE7: Fetch outside RAM and ROM resets
// RULE8: Illegal fetch drives pin; reset persists
// RULE9: Low voltage holds reset, then restabilises
// RULE10: Low-voltage detect works in stop, suspend
// RULE11: Stop turns oscillator and clocks off
// RULE12: Stop clears mask, sets interrupt enable
// RULE13: Stop keeps registers and pins unchanged
// RULE14: Stop exits only on listed wake events
// RULE15: Stop exit waits stabilisation delay
// RULE16: Wait halts processor clock, keeps state
// RULE17: Wait clears mask, sets interrupt enable
// RULE18: Wait exits on listed interrupts, resets; code omits bus and illegal-fetch resets
// RULE19: Board holds reset pin low in retention
// RULE20: System reset is a bus-clock latch
// RULE21: Release only when all sources ended
module rlp_ctrl #(
   parameter bit          CRYSTAL = 1'b1,
   parameter int unsigned STAB_W  = rlp_pkg::STAB_W
) (
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   input  wire logic                  clk_en,
   input  wire logic                  rst_pin_i,
   output logic                       rst_pin_o,
   output logic                       rst_pin_oe_n,
   input  wire logic                  low_voltage_i,
   input  wire logic                  osc_ready_i,
   input  wire logic                  usb_se0_i,
   input  wire logic                  usb_activity_i,
   input  wire logic                  usb_bit_tick,
   input  wire rlp_pkg::rlp_fetch_t   fetch,
   input  wire logic                  stop_exec,
   input  wire logic                  wait_exec,
   input  wire rlp_pkg::rlp_int_t     ints,
   output logic                       sys_rst,
   output logic                       usb_bus_reset_flag_set,
   output logic                       mode_update,
   output rlp_pkg::rlp_lp_side_t      lp_side,
   output logic                       osc_enable,
   output logic                       cpu_clk_en,
   output logic                       periph_clk_en,
   output rlp_pkg::rlp_pwr_state_t    pwr_state
);

   localparam int unsigned STAB_LEN =
      CRYSTAL ? rlp_pkg::STAB_CRYSTAL_CYC : rlp_pkg::STAB_CERAMIC_CYC;

   // Asynchronous inputs: 0 pin, 1 supply low, 2 osc ready, 3 se0, 4 activity
   logic [4:0] async_in;
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;

   assign async_in = {usb_activity_i, usb_se0_i, osc_ready_i, low_voltage_i, rst_pin_i};

   // Two-stage synchronisers, one per asynchronous input
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               sync1_reg[gi] <= rlp_pkg::SYNC_RST_VAL[gi];
               sync2_reg[gi] <= rlp_pkg::SYNC_RST_VAL[gi];
            end else if (clk_en) begin
               sync1_reg[gi] <= async_in[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   logic pin_s;
   logic lv_s;
   logic osc_s;
   logic se0_s;
   logic act_s;

   assign pin_s = sync2_reg[0];
   assign lv_s  = sync2_reg[1];
   assign osc_s = sync2_reg[2];
   assign se0_s = sync2_reg[3];
   assign act_s = sync2_reg[4];

   rlp_pkg::rlp_pwr_state_t state_reg;
   rlp_pkg::rlp_pwr_state_t state_next;
   logic       sys_rst_reg;
   logic       pin_drive_reg;
   logic [2:0] drive_hist_reg;
   logic [2:0] se0_cnt_reg;
   logic [2:0] se0_cnt_next;
   logic [3:0] ill_cnt_reg;
   logic [3:0] ill_cnt_next;
   logic       por_pend_reg;
   logic       usb_flag_reg;
   logic       mode_upd_reg;
   logic [3:0] src_prev_reg;
   logic [3:0] src_fell;
   rlp_pkg::rlp_lp_side_t lp_side_reg;

   // Reset source decode
   logic ext_act;
   logic lvr_act;
   logic usb_act;
   logic ill_act;
   logic ill_fetch;
   logic any_src;
   logic [3:0] src_vec;

   // Own drive echoes back through the synchroniser, so mask it
   assign ext_act  = !pin_s && !pin_drive_reg && (drive_hist_reg == '0); // see RULE1
   assign lvr_act  = lv_s; // see RULE10
   assign usb_act  = (se0_cnt_reg == rlp_pkg::USB_SE0_MIN_BITS); // see RULE6
   assign ill_act  = (ill_cnt_reg != '0);
   assign ill_fetch = fetch.valid && !sys_rst_reg &&
                      !((fetch.addr >= rlp_pkg::RAM_LO) && (fetch.addr <= rlp_pkg::RAM_HI)) &&
                      !((fetch.addr >= rlp_pkg::ROM_LO) && (fetch.addr <= rlp_pkg::ROM_HI)); // see RULE7
   assign any_src  = ext_act || lvr_act || usb_act || ill_act || por_pend_reg; // see RULE5
   assign src_vec  = {ill_act, usb_act, lvr_act, ext_act};

   // USB single-ended zero length counter, saturating at the reset length
   assign se0_cnt_next = !se0_s ? 3'h0 :
                         (usb_bit_tick && !usb_act) ? se0_cnt_reg + 3'h1 : se0_cnt_reg;

   // Illegal-fetch reset pulse length
   assign ill_cnt_next = ill_fetch ? rlp_pkg::ILL_HOLD_CYC :
                         ill_act ? ill_cnt_reg - 4'h1 : ill_cnt_reg;

   // Stabilisation timer control
   logic stab_start;
   logic stab_busy;
   logic stab_done;

   assign stab_start = lvr_act ||
                       (state_next == rlp_pkg::rlp_st_stab && state_reg != rlp_pkg::rlp_st_stab);

   rlp_stab_timer #(
      .LEN_CYC (STAB_LEN),
      .W       (STAB_W)
   ) u_stab (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .start    (stab_start),
      .count_en (osc_s),
      .busy     (stab_busy),
      .done     (stab_done)
   );

   // Wake conditions
   logic wake_stop;
   logic wake_wait;

   assign wake_stop = ints.irq || act_s || ext_act || usb_act || lvr_act; // see RULE14
   assign wake_wait = ints.irq || ints.usb || ints.timer1 || ints.multi_function_timer ||
                      lvr_act || ext_act; // see RULE18

   // Power state transitions
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rlp_pkg::rlp_st_stab: begin
            if (stab_done && !lvr_act) begin
               state_next = rlp_pkg::rlp_st_run; // see RULE15
            end
         end
         rlp_pkg::rlp_st_run: begin
            if (lvr_act) begin
               state_next = rlp_pkg::rlp_st_stab; // see RULE9
            end else if (stop_exec && !sys_rst_reg) begin
               state_next = rlp_pkg::rlp_st_stop;
            end else if (wait_exec && !sys_rst_reg) begin
               state_next = rlp_pkg::rlp_st_wait;
            end
         end
         rlp_pkg::rlp_st_wait: begin
            if (lvr_act) begin
               state_next = rlp_pkg::rlp_st_stab;
            end else if (wake_wait) begin
               state_next = rlp_pkg::rlp_st_run; // see RULE18
            end
         end
         rlp_pkg::rlp_st_stop: begin
            if (wake_stop) begin
               state_next = rlp_pkg::rlp_st_stab; // see RULE14
            end
         end
         default: begin
            state_next = rlp_pkg::rlp_st_stab;
         end
      endcase
   end

   // Falling edge of each mode-changing source
   generate
      for (gi = 0; gi < 4; gi++) begin : g_fell
         assign src_fell[gi] = src_prev_reg[gi] && !src_vec[gi];
      end
   endgenerate

   // State, pulse length and source counters
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg   <= rlp_pkg::rlp_st_stab;
         se0_cnt_reg <= 3'h0;
         ill_cnt_reg <= 4'h0;
      end else if (clk_en) begin
         state_reg   <= state_next;
         se0_cnt_reg <= se0_cnt_next; // see RULE6
         ill_cnt_reg <= ill_cnt_next; // see RULE7
      end
   end

   // Power-up pending flag: set by reset or low supply, cleared when stable
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         por_pend_reg <= 1'b1;
      end else if (clk_en) begin
         por_pend_reg <= lvr_act || (por_pend_reg && !stab_done); // see RULE4
      end
   end

   // Synchronous system reset latch
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sys_rst_reg <= 1'b1;
      end else if (clk_en) begin
         sys_rst_reg <= any_src; // see RULE20 see RULE21
      end
   end

   // Reset pin drive and its echo mask
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         pin_drive_reg  <= 1'b0;
         drive_hist_reg <= rlp_pkg::DRIVE_MASK_RST;
      end else if (clk_en) begin
         pin_drive_reg  <= lvr_act || ill_act; // see RULE2 see RULE8
         drive_hist_reg <= {drive_hist_reg[1:0], pin_drive_reg};
      end
   end

   // Event pulses: bus reset flag, mode update, instruction side effects
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         usb_flag_reg <= 1'b0;
         mode_upd_reg <= 1'b0;
         src_prev_reg <= 4'h0;
         lp_side_reg  <= '0;
      end else if (clk_en) begin
         usb_flag_reg <= se0_s && usb_bit_tick &&
                         (se0_cnt_reg == rlp_pkg::USB_SE0_MIN_BITS - 3'h1); // see RULE6
         mode_upd_reg <= |src_fell; // see RULE3
         src_prev_reg <= src_vec;
         lp_side_reg.clr_int_mask <= state_reg == rlp_pkg::rlp_st_run && !lvr_act &&
                                     !sys_rst_reg && (stop_exec || wait_exec); // see RULE12 see RULE17
         lp_side_reg.set_ext_int_enable <= state_reg == rlp_pkg::rlp_st_run && !lvr_act &&
                                           !sys_rst_reg && (stop_exec || wait_exec);
      end
   end

   // Outputs; in stop nothing else in the chip is clocked, in wait only the peripherals
   assign sys_rst                = sys_rst_reg;
   assign rst_pin_o              = 1'b0;
   assign rst_pin_oe_n           = !pin_drive_reg;
   assign usb_bus_reset_flag_set = usb_flag_reg;
   assign mode_update            = mode_upd_reg;
   assign lp_side                = lp_side_reg;
   assign osc_enable    = (state_reg != rlp_pkg::rlp_st_stop); // see RULE11
   assign cpu_clk_en    = (state_reg == rlp_pkg::rlp_st_run); // see RULE16
   assign periph_clk_en = (state_reg == rlp_pkg::rlp_st_run) ||
                          (state_reg == rlp_pkg::rlp_st_wait); // see RULE13
   assign pwr_state     = state_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_ext_pin_reset: assert property ((clk_en && ext_act) |=> sys_rst) // see RULE1
      else $error("external reset pin did not assert system reset");

   a_lvr_pin_drive: assert property ((clk_en && lvr_act) |=> !rst_pin_oe_n && !rst_pin_o) // see RULE2
      else $error("low voltage did not drive reset pin");

   a_mode_change_src: assert property (mode_update |-> $past(src_prev_reg) != 4'h0) // see RULE3
      else $error("mode update without a source ending");

   a_release_clean: assert property ($fell(sys_rst) |-> !$past(any_src)) // see RULE21
      else $error("system reset released while a source was active");

   a_usb_flag_set: assert property ((clk_en && se0_s && usb_bit_tick &&
                                     se0_cnt_reg == 3'h3) |=> usb_bus_reset_flag_set ##1 sys_rst) // see RULE6
      else $error("bus reset flag or reset missing");

   a_illegal_fetch: assert property ((clk_en && ill_fetch) |=> ill_act ##1 sys_rst) // see RULE7
      else $error("illegal fetch did not reset");

   a_ill_pin_drive: assert property ((clk_en && ill_act) |=> !rst_pin_oe_n) // see RULE8
      else $error("illegal fetch did not drive reset pin");

   a_stop_osc_off: assert property (state_reg == rlp_pkg::rlp_st_stop |-> !osc_enable && !cpu_clk_en
                                    && !periph_clk_en) // see RULE11
      else $error("clocks running while stopped");

   a_stop_lvr_wake: assert property ((clk_en && state_reg == rlp_pkg::rlp_st_stop && lvr_act)
                                     |=> state_reg == rlp_pkg::rlp_st_stab) // see RULE10
      else $error("low voltage ignored while stopped");

   a_stop_side_eff: assert property ((clk_en && state_reg == rlp_pkg::rlp_st_run && stop_exec &&
                                      !sys_rst_reg && !lvr_act) |=> lp_side.clr_int_mask
                                      && lp_side.set_ext_int_enable && state_reg == rlp_pkg::rlp_st_stop) // see RULE12
      else $error("stop entry side effects missing");

   a_wait_cpu_halt: assert property (state_reg == rlp_pkg::rlp_st_wait |-> !cpu_clk_en && periph_clk_en) // see RULE16
      else $error("processor clock running in wait");

   a_stab_before_run: assert property ((state_reg == rlp_pkg::rlp_st_run) &&
                                       $past(state_reg) == rlp_pkg::rlp_st_stab |-> !stab_busy) // see RULE15
      else $error("left stabilisation before count ended");

endmodule : rlp_ctrl

// ---- rlp_board_model.sv ----
// Far-side model: board reset circuit with pull-up and upstream bus line state.
// Assumes bench requests change off the rising edge of clk_sys.
`timescale 1ns/10ps
module rlp_board_model #(
   parameter int BIT_CYC = 10   // Bus clocks per USB bit time
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic rst_pin_o,
   input  wire logic rst_pin_oe_n,
   input  wire logic board_low,
   input  wire logic retention,
   input  wire logic se0_req,
   output logic      rst_pin_i,
   output logic      usb_se0_i,
   output logic      usb_bit_tick
);
   int tick_cnt;

   // Wired reset pin: pulled up unless a party pulls it low
   assign rst_pin_i = !(board_low || retention ||
                        (rst_pin_oe_n === 1'b0 && rst_pin_o === 1'b0));
   assign usb_se0_i = se0_req;

   // Free-running bit-time pulse
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tick_cnt <= 0;
         usb_bit_tick <= 1'b0;
      end else begin
         tick_cnt <= (tick_cnt == BIT_CYC - 1) ? 0 : tick_cnt + 1;
         usb_bit_tick <= (tick_cnt == BIT_CYC - 1);
      end
   end
endmodule : rlp_board_model

// ---- reset_lowpower_control_test.sv ----
// Self-checking bench for the reset and low-power controller.
// Assumes the controller built with the short 128-cycle stabilisation count.
`timescale 1ns/10ps
module reset_lowpower_control_test;
   logic clk_sys, nrst, osc_ready_i, low_voltage_i, usb_activity_i, stop_exec, wait_exec;
   logic board_low, retention, se0_req, rst_pin_i, rst_pin_o, rst_pin_oe_n;
   logic usb_se0_i, usb_bit_tick, sys_rst, flag_set, mode_update;
   logic osc_enable, cpu_clk_en, periph_clk_en, clk_en;
   rlp_pkg::rlp_fetch_t     fetch;
   rlp_pkg::rlp_int_t       ints;
   rlp_pkg::rlp_lp_side_t   lp_side;
   rlp_pkg::rlp_pwr_state_t pwr_state;
   int n_fail = 0, samples_checked = 0, mu_cnt = 0, fl_cnt = 0, lp_cnt = 0, n, k;
   logic [12:0] a;
   logic [12:0] corner [8] = '{13'h0080, 13'h00ff, 13'h1600, 13'h1fff,
                               13'h007f, 13'h0100, 13'h15ff, 13'h0000};

   rlp_ctrl #(.CRYSTAL(1'b0)) uut (
      .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .rst_pin_i(rst_pin_i),
      .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .low_voltage_i(low_voltage_i),
      .osc_ready_i(osc_ready_i), .usb_se0_i(usb_se0_i), .usb_activity_i(usb_activity_i),
      .usb_bit_tick(usb_bit_tick), .fetch(fetch), .stop_exec(stop_exec),
      .wait_exec(wait_exec), .ints(ints), .sys_rst(sys_rst),
      .usb_bus_reset_flag_set(flag_set), .mode_update(mode_update), .lp_side(lp_side),
      .osc_enable(osc_enable), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .pwr_state(pwr_state));

   rlp_board_model board (
      .clk_sys(clk_sys), .nrst(nrst), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n),
      .board_low(board_low), .retention(retention), .se0_req(se0_req),
      .rst_pin_i(rst_pin_i), .usb_se0_i(usb_se0_i), .usb_bit_tick(usb_bit_tick));

   // Clock, 8 ns period
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Pulse counters for one-cycle outputs
   always @(posedge clk_sys) begin
      if (mode_update === 1'b1) mu_cnt++;
      if (flag_set === 1'b1) fl_cnt++;
      if (lp_side === 2'b11) lp_cnt++;
   end

   function automatic logic legal(input logic [12:0] x);
      return (x >= rlp_pkg::RAM_LO && x <= rlp_pkg::RAM_HI) ||
             (x >= rlp_pkg::ROM_LO && x <= rlp_pkg::ROM_HI);
   endfunction : legal

   task automatic tick(input int c);
      repeat (c) @(negedge clk_sys);
   endtask : tick

   task automatic check(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH t=%0t %s", $time, what);
      end
   endtask : check

   task automatic wait_rst(input logic v, input int maxc);
      n = 0;
      while (sys_rst !== v && n < maxc) begin
         @(negedge clk_sys);
         n++;
      end
      check(sys_rst === v, "reset level not reached in time");
   endtask : wait_rst

   task automatic wait_run(input int maxc);
      n = 0;
      while (pwr_state !== rlp_pkg::rlp_st_run && n < maxc) begin
         @(negedge clk_sys);
         n++;
      end
      check(pwr_state === rlp_pkg::rlp_st_run, "run state not reached in time");
   endtask : wait_run

   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run

   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_fail++;
      complete_run();
   end

   // Main sequence
   initial begin
      {nrst, low_voltage_i, usb_activity_i, stop_exec, wait_exec} = 5'h00;
      {board_low, retention, se0_req} = 3'h0;
      osc_ready_i = 1'b1;
      clk_en = 1'b1;
      fetch = '0;
      ints = '0;
      void'($urandom(32'h0928c0ba));
      tick(20);
      nrst = 1'b1;
      wait_rst(1'b0, 200);
      check(n >= 128 && n <= 140, "power-up hold length");
      tick(2);
      check(pwr_state === rlp_pkg::rlp_st_run && cpu_clk_en === 1'b1, "run after power-up");
      check(mu_cnt == 0, "no mode update on power-up end");
      // Second reset with the pin held low past the count
      nrst = 1'b0;
      board_low = 1'b1;
      tick(3);
      nrst = 1'b1;
      tick(300);
      check(sys_rst === 1'b1, "held by pin after count");
      board_low = 1'b0;
      wait_rst(1'b0, 8);
      check(sys_rst === 1'b0, "release after last source");
      tick(10);
      // External reset of random length
      board_low = 1'b1;
      wait_rst(1'b1, 6);
      check(sys_rst === 1'b1, "pin low resets");
      tick(5 + $urandom % 20);
      check(sys_rst === 1'b1, "pin reset holds");
      mu_cnt = 0;
      board_low = 1'b0;
      wait_rst(1'b0, 8);
      tick(2);
      check(mu_cnt == 1, "mode update on pin reset end");
      // Fetch map corners then random addresses
      for (k = 0; k < 14; k++) begin
         a = (k < 8) ? corner[k] : 13'($urandom);
         mu_cnt = 0;
         fetch.valid = 1'b1;
         fetch.addr = a;
         tick(1);
         fetch.valid = 1'b0;
         tick(2);
         check(sys_rst === !legal(a), "fetch reset");
         check(rst_pin_oe_n === legal(a), "fetch pin drive");
         wait_rst(1'b0, 20);
         tick(8);
         check(mu_cnt == 32'(!legal(a)), "mode update on fetch reset end");
      end
      // Illegal fetch overlapped by low supply
      fetch.valid = 1'b1;
      fetch.addr = 13'h0000;
      tick(1);
      fetch.valid = 1'b0;
      low_voltage_i = 1'b1;
      tick(12);
      check(sys_rst === 1'b1, "reset persists past fetch reset");
      check(rst_pin_oe_n === 1'b0, "low supply drives pin");
      low_voltage_i = 1'b0;
      wait_rst(1'b0, 300);
      check(n >= 128 && n <= 140, "restabilise after low supply");
      tick(8);
      // Short then long single-ended zero
      fl_cnt = 0;
      se0_req = 1'b1;
      tick(25);
      se0_req = 1'b0;
      tick(4);
      check(sys_rst === 1'b0 && fl_cnt == 0, "short line zero ignored");
      se0_req = 1'b1;
      wait_rst(1'b1, 80);
      check(sys_rst === 1'b1 && fl_cnt == 1, "bus reset flag and reset");
      mu_cnt = 0;
      se0_req = 1'b0;
      wait_rst(1'b0, 10);
      tick(4);
      check(mu_cnt == 1, "mode update on bus reset end");
      // Stop, woken by the external interrupt and by bus activity
      for (k = 0; k < 2; k++) begin
         lp_cnt = 0;
         stop_exec = 1'b1;
         tick(1);
         stop_exec = 1'b0;
         check(pwr_state === rlp_pkg::rlp_st_stop && osc_enable === 1'b0, "stop");
         ints.timer1 = 1'b1;
         tick(10);
         ints.timer1 = 1'b0;
         check(pwr_state === rlp_pkg::rlp_st_stop, "stop kept");
         check(lp_cnt == 1, "stop side effects");
         check(sys_rst === 1'b0 && cpu_clk_en === 1'b0, "stop keeps state");
         if (k == 0) ints.irq = 1'b1;
         else usb_activity_i = 1'b1;
         wait_run(300);
         check(n >= 128 && n <= 140, "stop exit delay");
         ints.irq = 1'b0;
         usb_activity_i = 1'b0;
         tick(2);
      end
      // Low supply while stopped
      stop_exec = 1'b1;
      tick(1);
      stop_exec = 1'b0;
      tick(3);
      low_voltage_i = 1'b1;
      tick(6);
      check(sys_rst === 1'b1 && rst_pin_oe_n === 1'b0, "low supply in stop");
      low_voltage_i = 1'b0;
      wait_rst(1'b0, 300);
      tick(8);
      // Wait, woken by each interrupt kind
      for (k = 0; k < 4; k++) begin
         lp_cnt = 0;
         wait_exec = 1'b1;
         tick(1);
         wait_exec = 1'b0;
         tick(1);
         check(pwr_state === rlp_pkg::rlp_st_wait && cpu_clk_en === 1'b0 &&
               periph_clk_en === 1'b1, "wait state");
         check(lp_cnt == 1, "wait side effects");
         ints = rlp_pkg::rlp_int_t'(4'h8 >> k);
         wait_run(4);
         check(pwr_state === rlp_pkg::rlp_st_run, "wait wake");
         ints = '0;
         tick(2);
      end
      // Clock enable low freezes all state, even against a pin reset
      clk_en = 1'b0;
      board_low = 1'b1;
      tick(10);
      check(sys_rst === 1'b0 && pwr_state === rlp_pkg::rlp_st_run, "frozen");
      clk_en = 1'b1;
      wait_rst(1'b1, 6);
      check(sys_rst === 1'b1, "pin reset after enable");
      board_low = 1'b0;
      wait_rst(1'b0, 8);
      complete_run();
   end
endmodule : reset_lowpower_control_test
